// *** common/csdo_map.svh ***
// Purpose: offsets, field positions, reset values and timing counts for the clock select block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   definitions only
`ifndef CSDO_MAP_SVH
`define CSDO_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CSDO_OFF_CTRL      8'h00
`define CSDO_OFF_STATUS    8'h04
`define CSDO_OFF_INT_STAT  8'h08
`define CSDO_OFF_INT_MASK  8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define CSDO_CTRL_IDX_LSB  0
`define CSDO_CTRL_IDX_MSB  1
`define CSDO_ST_EXT        0
`define CSDO_ST_OPEN_A     1
`define CSDO_ST_OPEN_B     2
`define CSDO_ST_DIAG       3
`define CSDO_EV_EXT_ON     0
`define CSDO_EV_EXT_LOST   1
`define CSDO_EV_DIAG       2
`define CSDO_EV_OPEN       3
`define CSDO_NUM_EV        4

// ----------------------------------------
// reset values
// ----------------------------------------
`define CSDO_RST_MASK      4'h0
`define CSDO_RST_IDX       2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define CSDO_PCLK_HZ       100000000
`define CSDO_OSC_HZ        12000000
`define CSDO_OSC_DIV       (`CSDO_PCLK_HZ / `CSDO_OSC_HZ)
`define CSDO_LOSS_TICKS    32
`define CSDO_DIV_W         4
`define CSDO_LOSS_W        6

`endif

// *** common/csdo_pkg.sv ***
// Purpose: types shared by the clock select block
// Assumes: csdo_map.svh holds every number
// Notes:   none
package csdo_pkg;

   // clock source state, one-hot
   typedef enum logic [1:0] {
      CSDO_SRC_INT = 2'b01,
      CSDO_SRC_EXT = 2'b10
   } csdo_src_t;

   // signal routed to the position marker output
   typedef enum logic [1:0] {
      CSDO_IDX_ZERO = 2'h0,
      CSDO_IDX_STEP = 2'h1,
      CSDO_IDX_EXT  = 2'h2,
      CSDO_IDX_OSC  = 2'h3
   } csdo_idx_t;

endpackage

// *** design/csdo_top.sv ***
// Purpose: clock source selection, fault and position marker outputs, open-coil flags
// Assumes: pclk 100 MHz; internal oscillator modelled as an enable divided from pclk
// Notes:   the selected timebase leaves as a one-cycle enable, clk_tick
//          limitation: the oscillator divides pclk by 8, so it runs at 12.5 MHz
//
// Local design decisions: the APB register port and the register addresses.
`include "csdo_map.svh"
`timescale 1ns/1ps
`default_nettype none

module csdo_top
   import csdo_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_clk_pin,
   input  wire logic        coil_a_short_of_current,
   input  wire logic        coil_b_short_of_current,
   input  wire logic        drv_not_normal,
   input  wire logic        mscnt_zero,
   input  wire logic        step_pulse,
   input  wire logic [1:0]  otp_index_sel,
   output logic             clk_tick,
   output logic             clk_ext_sel,
   output logic             diag_out,
   output logic             index_out,
   output logic             open_coil_a,
   output logic             open_coil_b,
   output logic             irq
);

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   logic ext_s1_reg;
   logic ext_s2_reg;
   logic ext_s3_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_s3_reg <= 1'b0;
      end else begin
         ext_s1_reg <= ext_clk_pin;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
      end
   end

   // the third stage serves only edge detection; all other logic reads the second
   logic ext_rise;
   assign ext_rise = ext_s2_reg & ~ext_s3_reg;

   // ----------------------------------------
   // clock source selection
   // ----------------------------------------
   logic [`CSDO_DIV_W-1:0]  div_reg,  div_next;
   logic [`CSDO_LOSS_W-1:0] loss_reg, loss_next;
   csdo_src_t               src_reg,  src_next;
   logic                    lost_reg, lost_next;
   logic                    osc_tick;
   logic                    ev_ext_on;
   logic                    ev_ext_lost;

   assign osc_tick = (div_reg == `CSDO_DIV_W'(`CSDO_OSC_DIV - 1));

   always_comb begin
      div_next    = osc_tick ? '0 : div_reg + `CSDO_DIV_W'(1);
      loss_next   = loss_reg;
      src_next    = src_reg;
      lost_next   = lost_reg;
      ev_ext_on   = 1'b0;
      ev_ext_lost = 1'b0;
      unique case (src_reg)
         CSDO_SRC_INT: begin
            loss_next = '0;
            // a pin left high after a loss must toggle again before reselection
            if ((ext_s2_reg && !lost_reg) || ext_rise) begin
               src_next  = CSDO_SRC_EXT;
               lost_next = 1'b0;
               ev_ext_on = 1'b1;
            end
         end
         CSDO_SRC_EXT: begin
            if (ext_rise)
               loss_next = '0;
            else if (osc_tick)
               loss_next = loss_reg + `CSDO_LOSS_W'(1);
            if (osc_tick && !ext_rise && loss_reg == `CSDO_LOSS_W'(`CSDO_LOSS_TICKS - 1)) begin
               src_next    = CSDO_SRC_INT;
               lost_next   = 1'b1;
               ev_ext_lost = 1'b1;
            end
         end
         // an upset state code falls back to the always-running oscillator
         default: src_next = CSDO_SRC_INT;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg  <= '0;
         loss_reg <= '0;
         src_reg  <= CSDO_SRC_INT;
         lost_reg <= 1'b0;
      end else begin
         div_reg  <= div_next;
         loss_reg <= loss_next;
         src_reg  <= src_next;
         lost_reg <= lost_next;
      end
   end

   // one source per cycle, chosen by the registered state: no partial ticks at a switch
   logic tick_reg, tick_next;
   always_comb begin
      tick_next = (src_reg == CSDO_SRC_EXT) ? ext_rise : osc_tick;
   end

   // ----------------------------------------
   // diagnostic outputs
   // ----------------------------------------
   csdo_idx_t idx_sel_reg, idx_sel_next;
   logic      otp_done_reg;
   logic      diag_reg,  diag_next;
   logic      oa_reg,    oa_next;
   logic      ob_reg,    ob_next;
   logic      index_reg, index_next;
   logic      step_tgl_reg, step_tgl_next;

   always_comb begin
      diag_next     = drv_not_normal;
      oa_next       = coil_a_short_of_current;
      ob_next       = coil_b_short_of_current;
      step_tgl_next = step_tgl_reg ^ step_pulse;
      unique case (idx_sel_reg)
         CSDO_IDX_ZERO: index_next = mscnt_zero;
         CSDO_IDX_STEP: index_next = step_tgl_next;
         CSDO_IDX_EXT:  index_next = (src_reg == CSDO_SRC_EXT);
         CSDO_IDX_OSC:  index_next = tick_next;
      endcase
   end

   // flags follow their inputs one cycle late; no driver logic reads them back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_reg     <= 1'b0;
         diag_reg     <= 1'b0;
         oa_reg       <= 1'b0;
         ob_reg       <= 1'b0;
         index_reg    <= 1'b0;
         step_tgl_reg <= 1'b0;
      end else begin
         tick_reg     <= tick_next;
         diag_reg     <= diag_next;
         oa_reg       <= oa_next;
         ob_reg       <= ob_next;
         index_reg    <= index_next;
         step_tgl_reg <= step_tgl_next;
      end
   end

   // ----------------------------------------
   // APB slave and interrupts
   // ----------------------------------------
   logic                   ready_reg, ready_next;
   logic                   err_reg,   err_next;
   logic [31:0]            rdata_reg, rdata_next;
   logic [`CSDO_NUM_EV-1:0] ist_reg,  ist_next;
   logic [`CSDO_NUM_EV-1:0] imask_reg, imask_next;
   logic [`CSDO_NUM_EV-1:0] ev;
   logic                   irq_reg,   irq_next;
   logic                   wr_done;
   logic                   mapped;
   logic [3:0]             status;

   assign status = {diag_reg, ob_reg, oa_reg, src_reg == CSDO_SRC_EXT};
   // unmapped offsets answer with an error and change nothing
   assign mapped = (paddr == `CSDO_OFF_CTRL) || (paddr == `CSDO_OFF_STATUS) ||
                   (paddr == `CSDO_OFF_INT_STAT) || (paddr == `CSDO_OFF_INT_MASK);
   assign wr_done = psel && penable && ready_reg && pwrite && mapped;

   // open-coil event fires for either coil; the flags themselves stay live
   always_comb begin
      ev = '0;
      ev[`CSDO_EV_EXT_ON]   = ev_ext_on;
      ev[`CSDO_EV_EXT_LOST] = ev_ext_lost;
      ev[`CSDO_EV_DIAG]     = diag_next & ~diag_reg;
      ev[`CSDO_EV_OPEN]     = (oa_next & ~oa_reg) | (ob_next & ~ob_reg);
   end

   // bus response: one wait state, then a single-cycle ready pulse
   always_comb begin
      ready_next = psel && penable && !ready_reg;
      err_next   = ready_next && !mapped;
      rdata_next = '0;
      if (ready_next && !pwrite) begin
         unique case (paddr)
            `CSDO_OFF_CTRL:     rdata_next[`CSDO_CTRL_IDX_MSB:`CSDO_CTRL_IDX_LSB] = idx_sel_reg;
            `CSDO_OFF_STATUS:   rdata_next[3:0] = status;
            `CSDO_OFF_INT_STAT: rdata_next[`CSDO_NUM_EV-1:0] = ist_reg;
            `CSDO_OFF_INT_MASK: rdata_next[`CSDO_NUM_EV-1:0] = imask_reg;
            default:            rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_reg <= 1'b0;
         err_reg   <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ready_reg <= ready_next;
         err_reg   <= err_next;
         rdata_reg <= rdata_next;
      end
   end

   // configuration: marker selection takes the programmed value once after reset
   always_comb begin
      idx_sel_next = idx_sel_reg;
      imask_next   = imask_reg;
      if (!otp_done_reg)
         idx_sel_next = csdo_idx_t'(otp_index_sel);
      if (wr_done && paddr == `CSDO_OFF_CTRL)
         idx_sel_next = csdo_idx_t'(pwdata[`CSDO_CTRL_IDX_MSB:`CSDO_CTRL_IDX_LSB]);
      if (wr_done && paddr == `CSDO_OFF_INT_MASK)
         imask_next = pwdata[`CSDO_NUM_EV-1:0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_sel_reg  <= csdo_idx_t'(`CSDO_RST_IDX);
         otp_done_reg <= 1'b0;
         imask_reg    <= `CSDO_RST_MASK;
      end else begin
         idx_sel_reg  <= idx_sel_next;
         otp_done_reg <= 1'b1;
         imask_reg    <= imask_next;
      end
   end

   // interrupt status: a new event outranks a clear in the same cycle
   always_comb begin
      ist_next = ist_reg;
      if (wr_done && paddr == `CSDO_OFF_INT_STAT)
         ist_next = ist_reg & ~pwdata[`CSDO_NUM_EV-1:0];
      ist_next = ist_next | ev;
      irq_next = |(ist_next & imask_next);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         ist_reg <= ist_next;
         irq_reg <= irq_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata      = rdata_reg;
   assign pready      = ready_reg;
   assign pslverr     = err_reg;
   assign clk_tick    = tick_reg;
   assign clk_ext_sel = src_reg[1];
   assign diag_out    = diag_reg;
   assign index_out   = index_reg;
   assign open_coil_a = oa_reg;
   assign open_coil_b = ob_reg;
   assign irq         = irq_reg;

endmodule // csdo_top

`default_nettype wire

// *** verification/csdo_host.sv ***
// Purpose: host side, drives the external clock pin
// Assumes: pin toggles on pclk edges, half period in pclk cycles
// Notes: park lifts a stopped pin high and leaves it still
`timescale 1ns/1ps
`default_nettype none
module csdo_host (
   input  wire logic       pclk,
   input  wire logic       run,
   input  wire logic       park,
   input  wire logic [3:0] half,
   output logic            ext_clk_pin
);
   logic [3:0] cnt_reg;
   initial begin
      ext_clk_pin = 1'b0;
      cnt_reg = 4'h0;
   end
   // half of 4 or 5 gives 12.5 or 10 MHz
   always @(posedge pclk) begin
      if (run) begin
         cnt_reg <= (cnt_reg >= half - 4'h1) ? 4'h0 : cnt_reg + 4'h1;
         if (cnt_reg >= half - 4'h1) ext_clk_pin <= ~ext_clk_pin;
      end else if (park) ext_clk_pin <= 1'b1;
   end
endmodule // csdo_host
`default_nettype wire

// *** verification/csdo_monitor.sv ***
// Purpose: port checker for csdo_top
// Assumes: single pclk domain
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module csdo_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ext_clk_pin,
   input wire logic drv_not_normal,
   input wire logic coil_a_short_of_current,
   input wire logic coil_b_short_of_current,
   input wire logic clk_tick,
   input wire logic clk_ext_sel,
   input wire logic diag_out,
   input wire logic open_coil_a,
   input wire logic open_coil_b
);
   // cycles since the pin last moved, saturating
   logic [8:0] quiet_reg;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) quiet_reg <= 9'h000;
      else if ($changed(ext_clk_pin)) quiet_reg <= 9'h000;
      else if (quiet_reg != 9'h1FF) quiet_reg <= quiet_reg + 9'h001;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_diag; $past(presetn) |-> diag_out == $past(drv_not_normal); endproperty
   a_diag: assert property (p_diag) else $error("fault output wrong");
   property p_open_a; $past(presetn) |-> open_coil_a == $past(coil_a_short_of_current); endproperty
   a_open_a: assert property (p_open_a) else $error("coil a flag wrong");
   property p_open_b; $past(presetn) |-> open_coil_b == $past(coil_b_short_of_current); endproperty
   a_open_b: assert property (p_open_b) else $error("coil b flag wrong");
   property p_ext_on; $rose(ext_clk_pin) && !clk_ext_sel |-> ##[2:5] clk_ext_sel; endproperty
   a_ext_on: assert property (p_ext_on) else $error("no switch to pin clock");
   property p_loss_min; $fell(clk_ext_sel) |-> quiet_reg >= 9'd240; endproperty
   a_loss_min: assert property (p_loss_min) else $error("early fallback");
   property p_loss_max; quiet_reg == 9'd270 |-> !clk_ext_sel; endproperty
   a_loss_max: assert property (p_loss_max) else $error("late fallback");
   property p_osc;
      clk_tick && !clk_ext_sel |=> (!clk_tick || clk_ext_sel) [*7] ##1 (clk_tick || clk_ext_sel);
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator tick spacing");
   property p_ext_tick; clk_ext_sel && $rose(ext_clk_pin) |-> ##[1:4] clk_tick; endproperty
   a_ext_tick: assert property (p_ext_tick) else $error("pin edge gave no tick");
endmodule // csdo_monitor
bind csdo_top csdo_monitor u_mon (.pclk, .presetn, .ext_clk_pin, .drv_not_normal,
   .coil_a_short_of_current, .coil_b_short_of_current, .clk_tick, .clk_ext_sel,
   .diag_out, .open_coil_a, .open_coil_b);
`default_nettype wire

// *** verification/test_clock_select_and_diag_outputs.sv ***
// Purpose: self-checking bench for csdo_top
// Assumes: APB answers with one wait state
// Notes: fixed seed
`include "csdo_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_clock_select_and_diag_outputs;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, park = 0;
   logic coil_a_short_of_current = 0, coil_b_short_of_current = 0, drv_not_normal = 0;
   logic mscnt_zero = 0, step_pulse = 0, mz_d = 0, err;
   logic [1:0]  otp_index_sel = 2'h0;
   logic [3:0]  half = 4'h5;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, ext_clk_pin, clk_tick, clk_ext_sel, diag_out, index_out;
   logic open_coil_a, open_coil_b, irq;
   int miscompares = 0, checked = 0, n, c;
   always #5 pclk = ~pclk;
   csdo_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .ext_clk_pin, .coil_a_short_of_current, .coil_b_short_of_current, .drv_not_normal,
      .mscnt_zero, .step_pulse, .otp_index_sel, .clk_tick, .clk_ext_sel, .diag_out, .index_out,
      .open_coil_a, .open_coil_b, .irq);
   csdo_host u_host (.pclk, .run, .park, .half, .ext_clk_pin);
   function automatic int exp_ticks(input int cyc, input int per);
      return cyc / per;
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (miscompares == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // counts ticks, or marker highs, over 80 cycles
   task cnt(input logic use_idx);
      c = 0;
      repeat (80) begin
         @(posedge pclk);
         c += ((use_idx ? index_out : clk_tick) === 1'b1);
      end
   endtask
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end
   initial begin
      n = $urandom(16566);
      otp_index_sel = 2'($urandom_range(3, 0));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `CSDO_OFF_CTRL, 0);
      chk(rd, {30'h0, otp_index_sel});
      apb(0, `CSDO_OFF_INT_MASK, 0);
      chk(rd, 32'h0);
      apb(0, 8'h10, 0);
      chk({rd[30:0], err}, 32'h1);
      {coil_b_short_of_current, coil_a_short_of_current} <= 2'($urandom_range(3, 1));
      cnt(0);
      chk(c, exp_ticks(80, 8));
      apb(0, `CSDO_OFF_STATUS, 0);
      chk(rd[3:0], {1'b0, coil_b_short_of_current, coil_a_short_of_current, 1'b0});
      {coil_b_short_of_current, coil_a_short_of_current} <= 2'h0;
      apb(1, `CSDO_OFF_INT_MASK, 32'h4);
      drv_not_normal <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({diag_out, irq}, 2'h3);
      apb(1, `CSDO_OFF_INT_MASK, 0);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      apb(1, `CSDO_OFF_INT_MASK, 32'h4);
      drv_not_normal <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({diag_out, irq}, 2'h1);
      apb(1, `CSDO_OFF_INT_STAT, 32'hF);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      apb(1, `CSDO_OFF_CTRL, 0);
      @(posedge pclk);
      repeat (20) begin
         @(posedge pclk);
         chk(index_out, mz_d);
         mz_d = mscnt_zero;
         mscnt_zero <= 1'($urandom);
      end
      apb(1, `CSDO_OFF_CTRL, 1);
      for (n = 1; n <= 3; n++) begin
         @(posedge pclk) step_pulse <= 1'b1;
         @(posedge pclk) step_pulse <= 1'b0;
         repeat (4) @(posedge pclk);
         chk(index_out, n[0]);
      end
      apb(1, `CSDO_OFF_CTRL, 3);
      @(posedge pclk);
      cnt(1);
      chk(c, exp_ticks(80, 8));
      apb(1, `CSDO_OFF_CTRL, 2);
      apb(1, `CSDO_OFF_INT_MASK, 32'h3);
      run <= 1'b1;
      repeat (20) @(posedge pclk);
      chk({clk_ext_sel, index_out, irq}, 3'h7);
      cnt(0);
      chk(c, exp_ticks(80, 10));
      run <= 1'b0;
      park <= 1'b1;
      repeat (200) @(posedge pclk);
      chk(clk_ext_sel, 1);
      repeat (80) @(posedge pclk);
      chk(clk_ext_sel, 0);
      apb(0, `CSDO_OFF_INT_STAT, 0);
      chk(rd[3:0], 4'h3);
      cnt(0);
      chk({c[7:0], clk_ext_sel}, {8'(exp_ticks(80, 8)), 1'b0});
      park <= 1'b0;
      run <= 1'b1;
      repeat (30) @(posedge pclk);
      chk(clk_ext_sel, 1);
      end_sim();
   end
endmodule // test_clock_select_and_diag_outputs
`default_nettype wire
